// ### logic/dse_access.sv
// dse_access.sv: data-space decoder with register file, sram and nonvolatile access port
// assumes one core request at a time, held until cpu_ready, all on ref_clk
// Behaviour
// R1: short-form i/o accesses cannot reach the extended i/o region
// R2: low map order is register file, standard i/o, extended i/o
// R3: internal sram sits directly above extended i/o, 1024 bytes
// R4: direct addressing reaches every location up to the sram top
// R5: displacement mode adds 0..63 to the y or z pointer
// R6: pre-decrement and post-increment modes update the pointer pair
// R7: every region is reachable through all five addressing modes
// R8: each access completes in two clock cycles
// R9: nonvolatile space is 512 bytes, one byte per access
// R10: nonvolatile registers live in standard i/o space
// R11: a nonvolatile read halts the core for four cycles
// R12: a nonvolatile write start halts the core for two cycles
// R13: upper seven address bits read as zero
// R14: low nine address bits select the byte linearly
// R15: address bits are undefined after reset
// R16: software loads a valid address before any access
// R17: data register holds write byte or fetched read byte
// R18: writes are self-timed and busy is visible to software
// R19: software uses the guarded arm then strobe write sequence
// R20: write starts only within four cycles of arm; arm self-clears
// R21: write strobe clears itself when programming ends
// R22: software sets read strobe after the address, data is immediate
// R23: during a write, reads are rejected and the address is frozen
// R24: writes to reserved address bits are ignored
// R25: data register keeps its value until rewritten or read back
`include "dse_defines.svh"
module dse_access import dse_pkg::*; #(
    parameter int PROG_CYCLES = (`DSE_PROG_TIME_US * 1000 + `DSE_CLK_PERIOD_NS - 1)
        / `DSE_CLK_PERIOD_NS
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic cpu_req,
    input wire logic cpu_write,
    input wire logic cpu_io_form,
    input wire dse_mode_t cpu_mode,
    input wire dse_ptr_t cpu_ptr,
    input wire logic [5:0] cpu_disp,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    output logic cpu_ready,
    output logic cpu_done,
    output logic cpu_fault,
    output logic [7:0] cpu_rdata,
    output logic io_sel,
    output logic io_write,
    output logic [15:0] io_addr,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata
);
    // ****************************************************************
    // storage and state
    // ****************************************************************
    dse_state_t state, next_state;
    logic [7:0] regf [`DSE_REGF_SIZE];
    logic [7:0] sram [`DSE_SRAM_BYTES];
    logic [15:0] acc_addr;
    logic [7:0] acc_wdata;
    logic acc_write;
    logic acc_fault;
    logic acc_upd;
    logic [4:0] acc_base;
    logic [15:0] acc_ptr;
    logic [2:0] halt_cnt;
    logic [2:0] arm_cnt;
    logic nvm_arm;
    logic [`DSE_NVM_AW-1:0] nvm_address;
    logic [7:0] nvm_data_reg;
    logic [7:0] nvm_rdata;
    logic nvm_busy;
    logic [7:0] ctrl_view;
    logic [7:0] next_rdata;

    // ****************************************************************
    // request side: effective address generation
    // ****************************************************************
    // a request is taken only while the sequencer is idle
    assign cpu_ready = (state == st_idle);
    wire logic take = cpu_req && cpu_ready;

    // pointer pair base inside the register file
    wire logic [4:0] ptr_base = (cpu_ptr == ptr_x) ? `DSE_PTR_X :
        (cpu_ptr == ptr_y) ? `DSE_PTR_Y : `DSE_PTR_Z;
    wire logic [4:0] ptr_base_hi = ptr_base + `DSE_PTR_HIGH;
    wire logic [15:0] ptr_val = {regf[ptr_base_hi], regf[ptr_base]};

    // displacement is unsigned 0..63 above the base
    wire logic [15:0] ptr_disp = ptr_val + {`DSE_DISP_PAD, cpu_disp}; // R5
    wire logic [15:0] ptr_dec = ptr_val - `DSE_PTR_STEP;
    wire logic [15:0] ptr_inc = ptr_val + `DSE_PTR_STEP;

    // short form carries an i/o index, rebased above the register file
    wire logic [15:0] io_form_addr = cpu_addr + `DSE_STDIO_BASE;

    // every mode yields a full 16-bit address, so all regions stay reachable
    wire logic [15:0] eff_addr = cpu_io_form ? io_form_addr : // R7
        (cpu_mode == am_direct) ? cpu_addr : // R4
        (cpu_mode == am_disp) ? ptr_disp :
        (cpu_mode == am_predec) ? ptr_dec : ptr_val; // R6

    // pointer write-back value for the auto-modifying modes
    wire logic ptr_mod = !cpu_io_form && ((cpu_mode == am_predec) || (cpu_mode == am_postinc));
    wire logic [15:0] ptr_new = (cpu_mode == am_predec) ? ptr_dec : ptr_inc; // R6

    // illegal requests still complete, flagged, with no side effect
    wire logic bad_io_form = cpu_io_form && (cpu_addr >= `DSE_IO_SPAN); // R1
    wire logic bad_ptr = !cpu_io_form && (cpu_mode != am_direct) && (cpu_ptr == ptr_none);
    wire logic bad_disp = !cpu_io_form && (cpu_mode == am_disp) && (cpu_ptr == ptr_x); // R5
    wire logic bad_range = eff_addr > `DSE_SRAM_TOP; // R3
    wire logic req_fault = bad_io_form || bad_ptr || bad_disp || bad_range;

    // ****************************************************************
    // access side: region decode of the latched address
    // ****************************************************************
    // region order from the bottom: registers, standard i/o, extended i/o, sram
    wire logic in_acc = (state == st_acc);
    wire logic hit_regf = !acc_fault && (acc_addr < `DSE_STDIO_BASE); // R2
    wire logic hit_sram = !acc_fault && (acc_addr >= `DSE_SRAM_BASE); // R3
    wire logic hit_ctrl = !acc_fault && (acc_addr == `DSE_NVM_CTRL); // R10
    wire logic hit_data = !acc_fault && (acc_addr == `DSE_NVM_DATA); // R10
    wire logic hit_addrl = !acc_fault && (acc_addr == `DSE_NVM_ADDRL); // R10
    wire logic hit_addrh = !acc_fault && (acc_addr == `DSE_NVM_ADDRH); // R10
    wire logic hit_nvm = hit_ctrl || hit_data || hit_addrl || hit_addrh;
    // everything else between the register file and sram goes outside
    wire logic hit_io = !acc_fault && !hit_regf && !hit_sram && !hit_nvm; // R2

    wire logic acc_wr = in_acc && acc_write;
    wire logic wr_regf = acc_wr && hit_regf;
    wire logic wr_sram = acc_wr && hit_sram;
    wire logic [15:0] sram_off = acc_addr - `DSE_SRAM_BASE;
    wire logic [9:0] sram_idx = sram_off[9:0];

    // ****************************************************************
    // nonvolatile control decode
    // ****************************************************************
    wire logic ctrl_wr = acc_wr && hit_ctrl;
    // arm is taken only while the strobe bit is written as zero
    wire logic arm_set = ctrl_wr && acc_wdata[`DSE_BIT_ARM] && !acc_wdata[`DSE_BIT_WSTB];
    // the strobe only counts while the arm window is still open
    wire logic wr_trig = ctrl_wr && acc_wdata[`DSE_BIT_WSTB] && nvm_arm && !nvm_busy; // R20
    // a read during programming is dropped silently
    wire logic rd_trig = ctrl_wr && acc_wdata[`DSE_BIT_RSTB] && !nvm_busy && !wr_trig; // R23
    // address changes are locked out for the whole programming time
    wire logic addr_open = acc_wr && !nvm_busy; // R23

    // control readback: busy doubles as the write strobe bit, read strobe reads zero
    always_comb begin
        ctrl_view = `DSE_ZERO8;
        ctrl_view[`DSE_BIT_ARM] = nvm_arm;
        ctrl_view[`DSE_BIT_WSTB] = nvm_busy; // R18
    end

    // ****************************************************************
    // read data selection
    // ****************************************************************
    // faulted reads return zero; other non-internal addresses return io_rdata
    assign next_rdata = hit_regf ? regf[acc_addr[4:0]] :
        hit_ctrl ? ctrl_view :
        hit_data ? nvm_data_reg : // R17
        hit_addrl ? nvm_address[7:0] : // R14
        hit_addrh ? {`DSE_ZERO7, nvm_address[8]} : // R13
        hit_sram ? sram[sram_idx] :
        hit_io ? io_rdata : `DSE_ZERO8;

    // outside i/o strobe is qualified by the access cycle
    assign io_sel = in_acc && hit_io;
    assign io_write = acc_write;
    assign io_addr = acc_addr;
    assign io_wdata = acc_wdata;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    // idle takes a request, acc is the second cycle, halt holds the core
    always_comb begin
        next_state = state;
        case (state)
            st_idle: begin
                if (take) begin
                    next_state = st_acc; // R8
                end
            end
            st_acc: begin
                if (rd_trig || wr_trig) begin
                    next_state = st_halt; // R11
                end else begin
                    next_state = st_idle;
                end
            end
            st_halt: begin
                if (halt_cnt == `DSE_CNT_LAST) begin
                    next_state = st_idle;
                end
            end
            default: begin
                next_state = st_idle;
            end
        endcase
    end

    // state, halt timer and completion flags
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= st_idle;
            halt_cnt <= '0;
            cpu_done <= 1'b0;
            cpu_fault <= 1'b0;
            cpu_rdata <= `DSE_ZERO8;
        end else begin
            state <= next_state;
            halt_cnt <= in_acc ? (rd_trig ? `DSE_RD_HALT : `DSE_WR_HALT) : // R11 R12
                halt_cnt - `DSE_CNT_LAST;
            cpu_done <= in_acc; // R8
            cpu_fault <= in_acc && acc_fault;
            cpu_rdata <= in_acc ? next_rdata : cpu_rdata;
        end
    end

    // latch of the taken request; reset keeps the outside i/o bus quiet
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            acc_addr <= '0;
            acc_wdata <= `DSE_ZERO8;
            acc_write <= 1'b0;
            acc_fault <= 1'b0;
            acc_upd <= 1'b0;
            acc_base <= '0;
            acc_ptr <= '0;
        end else if (take) begin
            acc_addr <= eff_addr;
            acc_wdata <= cpu_wdata;
            acc_write <= cpu_write;
            acc_fault <= req_fault;
            acc_upd <= ptr_mod && !req_fault; // R6
            acc_base <= ptr_base;
            acc_ptr <= ptr_new;
        end
    end

    // ****************************************************************
    // register file and sram
    // ****************************************************************
    // pointer write-back wins over a store that hits the same pointer byte
    for (genvar i = 0; i < `DSE_REGF_SIZE; i++) begin : g_regf
        always_ff @(posedge ref_clk) begin
            if (in_acc && acc_upd && (acc_base == 5'(i))) begin
                regf[i] <= acc_ptr[7:0]; // R6
            end else if (in_acc && acc_upd && ((acc_base + `DSE_PTR_HIGH) == 5'(i))) begin
                regf[i] <= acc_ptr[15:8]; // R6
            end else if (wr_regf && (acc_addr[4:0] == 5'(i))) begin
                regf[i] <= acc_wdata; // R2
            end
        end
    end

    // sram store lands at the end of the second cycle
    always_ff @(posedge ref_clk) begin
        if (wr_sram) begin
            sram[sram_idx] <= acc_wdata; // R3
        end
    end

    // ****************************************************************
    // nonvolatile access registers
    // ****************************************************************
    // address has no reset value on purpose; software must load it first
    always_ff @(posedge ref_clk) begin
        if (addr_open && hit_addrl) begin
            nvm_address[7:0] <= acc_wdata; // R14 R15
        end
        if (addr_open && hit_addrh) begin
            nvm_address[8] <= acc_wdata[0]; // R24
        end
    end

    // data register: loaded by software or by a read, otherwise held
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            nvm_data_reg <= `DSE_ZERO8;
        end else if (rd_trig) begin
            nvm_data_reg <= nvm_rdata; // R17 R25
        end else if (acc_wr && hit_data) begin
            nvm_data_reg <= acc_wdata; // R17 R25
        end
    end

    // arm window: a fresh arm reloads the timer before any clear is looked at
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            nvm_arm <= 1'b0;
            arm_cnt <= '0;
        end else if (arm_set) begin
            nvm_arm <= 1'b1; // R20
            arm_cnt <= `DSE_ARM_CYCLES;
        end else if (wr_trig) begin
            nvm_arm <= 1'b0;
            arm_cnt <= '0;
        end else if (nvm_arm) begin
            nvm_arm <= (arm_cnt != `DSE_CNT_LAST); // R20
            arm_cnt <= arm_cnt - `DSE_CNT_LAST;
        end
    end

    // cell array with its own programming timer
    dse_nvm_array #(
        .PROG_CYCLES(PROG_CYCLES)
    ) u_cells (
        .ref_clk(ref_clk),
        .reset(reset),
        .rd_addr(nvm_address),
        .wr_start(wr_trig),
        .wr_data(nvm_data_reg),
        .rd_data(nvm_rdata),
        .busy(nvm_busy)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking dse_cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    io_form_fault_a: assert property ( // R1
        take && cpu_io_form && (cpu_addr >= `DSE_IO_SPAN) |-> ##2 cpu_done && cpu_fault)
        else $error("short-form access beyond standard i/o not faulted");

    regf_store_a: assert property ( // R2
        take && cpu_write && !cpu_io_form && (cpu_mode == am_direct)
        && (cpu_addr < `DSE_STDIO_BASE)
        |-> ##2 regf[$past(cpu_addr[4:0], 2)] == $past(cpu_wdata, 2))
        else $error("direct store to the register file lost");

    direct_reach_a: assert property ( // R4
        take && !cpu_io_form && (cpu_mode == am_direct) && (cpu_addr <= `DSE_SRAM_TOP)
        |-> ##2 cpu_done && !cpu_fault)
        else $error("direct access inside the map faulted");

    post_inc_a: assert property ( // R6
        take && !cpu_write && !cpu_io_form && (cpu_mode == am_postinc) && (cpu_ptr == ptr_x)
        |-> ##2 {regf[`DSE_PTR_X + `DSE_PTR_HIGH], regf[`DSE_PTR_X]}
        == $past(ptr_val, 2) + `DSE_PTR_STEP)
        else $error("pointer not incremented after access");

    two_cycle_a: assert property ( // R8
        take |=> in_acc ##1 cpu_done)
        else $error("access did not complete in two cycles");

    read_halt_a: assert property ( // R11
        rd_trig |=> (state == st_halt)[*4] ##1 cpu_ready)
        else $error("read halt is not four cycles");

    write_halt_a: assert property ( // R12
        wr_trig |=> (state == st_halt)[*2] ##1 cpu_ready)
        else $error("write halt is not two cycles");

    addr_high_zero_a: assert property ( // R13
        in_acc && hit_addrh |=> cpu_rdata[7:1] == `DSE_ZERO7)
        else $error("reserved address bits read nonzero");

    arm_timeout_a: assert property ( // R20
        arm_set ##1 (!wr_trig && !arm_set)[*4] |=> !nvm_arm)
        else $error("arm not cleared after four cycles");

    busy_read_a: assert property ( // R23
        ctrl_wr && acc_wdata[`DSE_BIT_RSTB] && nvm_busy |=> $stable(nvm_data_reg) && cpu_ready)
        else $error("read accepted during programming");

    addr_frozen_a: assert property ( // R23
        acc_wr && (hit_addrl || hit_addrh) && nvm_busy |=> $stable(nvm_address))
        else $error("address changed during programming");
endmodule : dse_access

// ### logic/dse_defines.svh
// dse_defines.svh: address map, register bits and timing figures of the data-space block
// assumes inclusion by bare name from every design file that decodes or times accesses
`ifndef DSE_DEFINES_SVH
`define DSE_DEFINES_SVH

// ****************************************************************
// data space map
// ****************************************************************
`define DSE_REGF_SIZE 32
`define DSE_STDIO_BASE 16'h0020
`define DSE_EXTIO_BASE 16'h0060
`define DSE_SRAM_BASE 16'h0100
`define DSE_SRAM_TOP 16'h04ff
`define DSE_SRAM_BYTES 1024
`define DSE_IO_SPAN 16'h0040
`define DSE_DISP_PAD 10'h000
`define DSE_PTR_STEP 16'h0001
`define DSE_PTR_X 5'h1a
`define DSE_PTR_Y 5'h1c
`define DSE_PTR_Z 5'h1e
`define DSE_PTR_HIGH 5'h01

// ****************************************************************
// nonvolatile access registers in the standard i/o region
// ****************************************************************
`define DSE_NVM_CTRL 16'h003f
`define DSE_NVM_DATA 16'h0040
`define DSE_NVM_ADDRL 16'h0041
`define DSE_NVM_ADDRH 16'h0042
`define DSE_BIT_ARM 2
`define DSE_BIT_WSTB 1
`define DSE_BIT_RSTB 0
`define DSE_NVM_BYTES 512
`define DSE_NVM_AW 9
`define DSE_ZERO7 7'h00
`define DSE_ZERO8 8'h00

// ****************************************************************
// timing
// ****************************************************************
`define DSE_CLK_PERIOD_NS 40
`define DSE_PROG_TIME_US 3400
`define DSE_ARM_CYCLES 3'h4
`define DSE_RD_HALT 3'h4
`define DSE_WR_HALT 3'h2
`define DSE_CNT_LAST 3'h1
`define DSE_PROG_CW 17
`define DSE_PROG_LAST 17'h0_0001

`endif

// ### logic/dse_nvm_array.sv
// dse_nvm_array.sv: 512-byte nonvolatile cell array with a self-timed write
// assumes nothing of address and data after write start; both are latched then for the whole programming time
`include "dse_defines.svh"
module dse_nvm_array import dse_pkg::*; #(
    parameter int PROG_CYCLES = 1
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [`DSE_NVM_AW-1:0] rd_addr,
    input wire logic wr_start,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    output logic busy
);
    logic [7:0] cells [`DSE_NVM_BYTES];
    logic [`DSE_NVM_AW-1:0] wr_addr_q;
    logic [7:0] wr_data_q;
    logic [`DSE_PROG_CW-1:0] prog_cnt;
    wire logic prog_end = busy && (prog_cnt == `DSE_PROG_LAST);

    // reads are immediate; the caller blocks them while busy
    assign rd_data = cells[rd_addr];

    // programming timer, busy drops by itself at the end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            busy <= 1'b0;
            prog_cnt <= '0;
        end else if (wr_start && !busy) begin
            busy <= 1'b1; // R18
            prog_cnt <= `DSE_PROG_CW'(PROG_CYCLES);
        end else if (busy) begin
            busy <= !prog_end; // R21
            prog_cnt <= prog_cnt - `DSE_PROG_LAST;
        end
    end

    // the byte lands in the cell at the last programming cycle
    always_ff @(posedge ref_clk) begin
        if (wr_start && !busy) begin
            wr_addr_q <= rd_addr;
            wr_data_q <= wr_data;
        end
        if (prog_end) begin
            cells[wr_addr_q] <= wr_data_q; // R9
        end
    end

    prog_count_a: assert property (@(posedge ref_clk) disable iff (reset) // R18
        busy |-> prog_cnt != '0) else $error("busy with an empty programming timer");
endmodule : dse_nvm_array

// ### logic/dse_pkg.sv
// dse_pkg.sv: types shared by the data-space block
// assumes nothing beyond a sv compiler
package dse_pkg;
    // addressing mode of one data access
    typedef enum logic [2:0] {am_direct, am_indirect, am_disp, am_predec, am_postinc} dse_mode_t;
    // pointer pair selector
    typedef enum logic [1:0] {ptr_x, ptr_y, ptr_z, ptr_none} dse_ptr_t;
    // access sequencer
    typedef enum logic [1:0] {st_idle, st_acc, st_halt} dse_state_t;
endpackage : dse_pkg

// ### testbench/data_space_eeprom_access_tb.sv
// data_space_eeprom_access_tb.sv: self-checking bench for the data-space access block
// assumes a shortened programming time and the i/o responder model on the far side
module data_space_eeprom_access_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import dse_pkg::*;
    typedef struct {
        logic w; logic io; dse_mode_t m; dse_ptr_t p; logic [5:0] dp;
        logic [15:0] a; logic [7:0] d; logic [7:0] e; logic f;
    } dse_row_t;
    logic ref_clk = 1'h0, reset = 1'h1, cpu_req = 1'h0, cpu_write = 1'h0, cpu_io_form = 1'h0;
    dse_mode_t cpu_mode = am_direct;
    dse_ptr_t cpu_ptr = ptr_none;
    logic [5:0] cpu_disp = 6'h00;
    logic [15:0] cpu_addr = 16'h0000;
    logic [7:0] cpu_wdata = 8'h00, cpu_rdata, io_wdata, io_rdata, rd;
    logic cpu_ready, cpu_done, cpu_fault, io_sel, io_write, f;
    logic [15:0] io_addr;
    int fail_count = 0, total_checks = 0, cycles = 0, h, n;
    dse_row_t rows [25] = '{
        '{1'h1, 1'h0, am_direct, ptr_none, 6'h00, 16'h001c, 8'h00, 8'h00, 1'h0},
        '{1'h1, 1'h0, am_direct, ptr_none, 6'h00, 16'h001d, 8'h01, 8'h00, 1'h0},
        '{1'h1, 1'h0, am_direct, ptr_none, 6'h00, 16'h0110, 8'ha5, 8'h00, 1'h0},
        '{1'h0, 1'h0, am_disp, ptr_y, 6'h10, 16'h0000, 8'h00, 8'ha5, 1'h0},
        '{1'h1, 1'h0, am_direct, ptr_none, 6'h00, 16'h04ff, 8'h3c, 8'h00, 1'h0},
        '{1'h0, 1'h0, am_direct, ptr_none, 6'h00, 16'h04ff, 8'h00, 8'h3c, 1'h0},
        '{1'h0, 1'h0, am_direct, ptr_none, 6'h00, 16'h0500, 8'h00, 8'h00, 1'h1},
        '{1'h1, 1'h0, am_direct, ptr_none, 6'h00, 16'h001e, 8'h00, 8'h00, 1'h0},
        '{1'h1, 1'h0, am_direct, ptr_none, 6'h00, 16'h001f, 8'h01, 8'h00, 1'h0},
        '{1'h1, 1'h0, am_postinc, ptr_z, 6'h00, 16'h0000, 8'h11, 8'h00, 1'h0},
        '{1'h0, 1'h0, am_direct, ptr_none, 6'h00, 16'h001e, 8'h00, 8'h01, 1'h0},
        '{1'h1, 1'h0, am_predec, ptr_z, 6'h00, 16'h0000, 8'h22, 8'h00, 1'h0},
        '{1'h0, 1'h0, am_indirect, ptr_z, 6'h00, 16'h0000, 8'h00, 8'h22, 1'h0},
        '{1'h0, 1'h0, am_direct, ptr_none, 6'h00, 16'h001e, 8'h00, 8'h00, 1'h0},
        '{1'h1, 1'h0, am_direct, ptr_none, 6'h00, 16'h001a, 8'h05, 8'h00, 1'h0},
        '{1'h1, 1'h0, am_direct, ptr_none, 6'h00, 16'h001b, 8'h00, 8'h00, 1'h0},
        '{1'h1, 1'h0, am_indirect, ptr_x, 6'h00, 16'h0000, 8'h77, 8'h00, 1'h0},
        '{1'h0, 1'h0, am_direct, ptr_none, 6'h00, 16'h0005, 8'h00, 8'h77, 1'h0},
        '{1'h0, 1'h0, am_postinc, ptr_x, 6'h00, 16'h0000, 8'h00, 8'h77, 1'h0},
        '{1'h0, 1'h0, am_direct, ptr_none, 6'h00, 16'h001a, 8'h00, 8'h06, 1'h0},
        '{1'h0, 1'h0, am_direct, ptr_none, 6'h00, 16'h0080, 8'h00, 8'hda, 1'h0},
        '{1'h0, 1'h1, am_direct, ptr_none, 6'h00, 16'h0010, 8'h00, 8'h6a, 1'h0},
        '{1'h0, 1'h1, am_direct, ptr_none, 6'h00, 16'h0060, 8'h00, 8'h00, 1'h1},
        '{1'h0, 1'h0, am_disp, ptr_x, 6'h01, 16'h0000, 8'h00, 8'h00, 1'h1},
        '{1'h0, 1'h0, am_indirect, ptr_none, 6'h00, 16'h0000, 8'h00, 8'h00, 1'h1}
    };
    // a short programming time keeps polling loops brief
    dse_access #(.PROG_CYCLES(20)) dut (.ref_clk(ref_clk), .reset(reset), .cpu_req(cpu_req),
        .cpu_write(cpu_write), .cpu_io_form(cpu_io_form), .cpu_mode(cpu_mode),
        .cpu_ptr(cpu_ptr), .cpu_disp(cpu_disp), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_ready(cpu_ready), .cpu_done(cpu_done), .cpu_fault(cpu_fault),
        .cpu_rdata(cpu_rdata), .io_sel(io_sel), .io_write(io_write), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_rdata(io_rdata));
    dse_io_model io_side (.ref_clk(ref_clk), .io_sel(io_sel), .io_addr(io_addr),
        .io_rdata(io_rdata));
    // ****************************************************************
    // clock, timeout and shared tasks
    // ****************************************************************
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            results();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // request is raised at a falling edge and held until an edge finds the block ready
    task automatic acc(input logic w, input logic io, input dse_mode_t m, input dse_ptr_t p,
            input logic [5:0] dp, input logic [15:0] a, input logic [7:0] d);
        cpu_req = 1'h1; cpu_write = w; cpu_io_form = io; cpu_mode = m;
        cpu_ptr = p; cpu_disp = dp; cpu_addr = a; cpu_wdata = d;
        while (cpu_ready !== 1'h1) @(negedge ref_clk);
        @(negedge ref_clk);
        cpu_req = 1'h0;
        @(negedge ref_clk);
        check({7'h00, cpu_done}, 8'h01);
        rd = cpu_rdata;
        f = cpu_fault;
        h = 0;
        while (cpu_ready !== 1'h1 && h < 10) begin
            h++;
            @(negedge ref_clk);
        end
    endtask : acc
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        acc(1'h1, 1'h0, am_direct, ptr_none, 6'h00, a, d);
    endtask : wr
    task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
        acc(1'h0, 1'h0, am_direct, ptr_none, 6'h00, a, 8'h00);
        check(rd, e);
    endtask : rdchk
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (12) @(negedge ref_clk);
        reset = 1'h0;
        check({cpu_ready, cpu_done, cpu_fault, 5'h00}, 8'h80);
        check(cpu_rdata, 8'h00);
        foreach (rows[i]) begin
            acc(rows[i].w, rows[i].io, rows[i].m, rows[i].p, rows[i].dp, rows[i].a, rows[i].d);
            if (!rows[i].w) check(rd, rows[i].e);
            check({7'h00, f}, {7'h00, rows[i].f});
        end
        // outside i/o store: the latched request stays on the bus until the next take
        wr(16'h0080, 8'h5c);
        check(io_wdata, 8'h5c);
        check(io_addr[7:0], 8'h80);
        check(io_addr[15:8], 8'h00);
        check({7'h00, io_write}, 8'h01);
        wr(16'h0042, 8'hff);
        rdchk(16'h0042, 8'h01);
        wr(16'h0041, 8'h34);
        wr(16'h0040, 8'hc3);
        wr(16'h003f, 8'h04);
        acc(1'h1, 1'h0, am_direct, ptr_none, 6'h00, 16'h003f, 8'h02);
        check(h[7:0], 8'h02);
        rdchk(16'h003f, 8'h02);
        wr(16'h0041, 8'h00);
        acc(1'h1, 1'h0, am_direct, ptr_none, 6'h00, 16'h003f, 8'h01);
        check(h[7:0], 8'h00);
        rdchk(16'h0041, 8'h34);
        n = 0;
        do begin
            acc(1'h0, 1'h0, am_direct, ptr_none, 6'h00, 16'h003f, 8'h00);
            n++;
        end while (rd[1] !== 1'h0 && n < 40);
        check(rd, 8'h00);
        wr(16'h0040, 8'h00);
        acc(1'h1, 1'h0, am_direct, ptr_none, 6'h00, 16'h003f, 8'h01);
        check(h[7:0], 8'h04);
        rdchk(16'h0040, 8'hc3);
        rdchk(16'h0040, 8'hc3);
        // strobe without arm, then strobe after the arm window: neither may program
        wr(16'h0040, 8'h99);
        acc(1'h1, 1'h0, am_direct, ptr_none, 6'h00, 16'h003f, 8'h02);
        check(h[7:0], 8'h00);
        wr(16'h003f, 8'h04);
        rdchk(16'h0110, 8'ha5);
        rdchk(16'h0110, 8'ha5);
        acc(1'h1, 1'h0, am_direct, ptr_none, 6'h00, 16'h003f, 8'h02);
        check(h[7:0], 8'h00);
        acc(1'h1, 1'h0, am_direct, ptr_none, 6'h00, 16'h003f, 8'h01);
        rdchk(16'h0040, 8'hc3);
        // second reset in mid-run
        reset = 1'h1;
        repeat (2) @(negedge ref_clk);
        reset = 1'h0;
        check({cpu_ready, cpu_done, cpu_fault, io_sel, 4'h0}, 8'h80);
        check(cpu_rdata, 8'h00);
        results();
    end
endmodule : data_space_eeprom_access_tb

// ### testbench/dse_io_model.sv
// dse_io_model.sv: responder for the outside i/o registers beside the data-space block
// assumes the block selects it for one combinational cycle and samples io_rdata then
module dse_io_model (
    input wire logic ref_clk,
    input wire logic io_sel,
    input wire logic [15:0] io_addr,
    output logic [7:0] io_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] last_out;
    // ****************************************************************
    // answer
    // ****************************************************************
    // a released bus shows the inverse of its last value, so a stale byte never matches
    assign io_rdata = io_sel ? (io_addr[7:0] ^ 8'h5a) : ~last_out;
    always_ff @(posedge ref_clk) begin
        last_out <= io_rdata;
    end
endmodule : dse_io_model
